// ---- hdl/wrap_pos_pkg.sv ----
package wrap_pos_pkg;

  localparam int unsigned ENTRY_COUNT = 64;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned POS_W = 24;
  localparam int unsigned RANGE_W = 23;
  localparam int unsigned RATE_W = 20;
  localparam int unsigned PUSH_W = 9;
  localparam int unsigned DWELL_W = 16;
  localparam int unsigned GEAR_W = 16;
  localparam int unsigned MROT_W = 16;

  // Setting limits
  localparam logic [RANGE_W-1:0] WRAP_RANGE_MIN = 23'h000001;
  localparam logic [RATE_W-1:0] SPEED_MAX = 20'hf4240;
  localparam logic [RATE_W-1:0] RATE_MIN = 20'h00001;
  localparam logic [RATE_W-1:0] RATE_MAX = 20'hf4240;
  localparam logic [PUSH_W-1:0] PUSH_MAX = 9'h1f4;
  localparam logic [DWELL_W-1:0] DWELL_MAX = 16'hc350;

  // Gear check factors
  localparam logic [9:0] GEAR_B_FACTOR = 10'h3e8;
  localparam logic [5:0] GEAR_A_FACTOR = 6'h32;

  // Values after reset, and the last table index
  localparam logic [RANGE_W-1:0] WRAP_RANGE_RST = 23'h0003e8;
  localparam logic [RATE_W-1:0] SPEED_RST = 20'h003e8;
  localparam logic [RATE_W-1:0] RATE_RST = 20'h003e8;
  localparam logic [PUSH_W-1:0] PUSH_RST = 9'h0c8;
  localparam logic [GEAR_W-1:0] GEAR_RST = 16'h0001;
  localparam logic [IDX_W-1:0] LAST_IDX = 6'h3f;

  typedef enum logic {
    target_incremental,
    absolute_target_mode
  } target_mode_t;

  typedef enum logic [1:0] {
    chain_single,
    chain_linked,
    chain_linked_dwell,
    chain_push
  } chain_t;

  typedef enum logic [1:0] {
    upd_immediate,
    upd_after_stop,
    upd_after_config,
    upd_after_power
  } update_class_t;

  typedef struct packed {
    logic signed [POS_W-1:0] position;
    logic [RATE_W-1:0] speed;
    target_mode_t mode;
    chain_t chain;
    logic [RATE_W-1:0] accel;
    logic [RATE_W-1:0] decel;
    logic [PUSH_W-1:0] push_current;
    logic seq_enable;
    logic [DWELL_W-1:0] dwell;
  } op_entry_t;

  typedef struct packed {
    logic wrap_enable;
    logic [RANGE_W-1:0] wrap_range;
    logic [GEAR_W-1:0] gear_a;
    logic [GEAR_W-1:0] gear_b;
    logic rth_alarm_enable;
    logic soft_ot_enable;
    logic rate_separate;
    logic [RATE_W-1:0] common_accel;
    logic [RATE_W-1:0] common_decel;
  } param_t;

  localparam op_entry_t ENTRY_RST = '{position: '0, speed: SPEED_RST,
    mode: target_incremental, chain: chain_single, accel: RATE_RST,
    decel: RATE_RST, push_current: PUSH_RST, seq_enable: 1'b0,
    dwell: '0};

  localparam param_t PARAM_RST = '{wrap_enable: 1'b0,
    wrap_range: WRAP_RANGE_RST, gear_a: GEAR_RST, gear_b: GEAR_RST,
    rth_alarm_enable: 1'b0, soft_ot_enable: 1'b0, rate_separate: 1'b1,
    common_accel: RATE_RST, common_decel: RATE_RST};

endpackage

// ---- hdl/wrap_position_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none

module wrap_position_ctrl
  import wrap_pos_pkg::*;
#(
  parameter int unsigned GEAR_BITS = GEAR_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic step_up_i,
  input wire logic preset_i,
  input wire logic home_done_i,
  input wire logic motion_i,
  input wire logic start_pos_i,
  input wire logic config_i,
  input wire logic alarm_clr_i,
  input wire logic [IDX_W-1:0] sel_idx_i,
  input wire logic entry_wr_i,
  input wire logic [IDX_W-1:0] entry_idx_i,
  input wire op_entry_t entry_data_i,
  input wire logic param_wr_i,
  input wire param_t param_data_i,
  input wire op_entry_t nvm_entry_i,
  input wire param_t nvm_param_i,
  output logic [IDX_W-1:0] nvm_addr_o,
  output logic ready_o,
  output logic wr_err_o,
  output logic signed [POS_W-1:0] cmd_pos_o,
  output logic signed [MROT_W-1:0] multi_rot_o,
  output logic soft_ot_en_o,
  output logic wrap_warn_o,
  output logic wrap_alarm_o,
  output logic rth_alarm_o,
  output logic origin_set_o,
  output op_entry_t entry_o,
  output logic signed [POS_W-1:0] target_o,
  output logic [RATE_W-1:0] eff_accel_o,
  output logic [RATE_W-1:0] eff_decel_o,
  output logic [PUSH_W-1:0] push_current_o,
  output logic [DWELL_W-1:0] dwell_o,
  output logic linked_o,
  output logic push_mode_o,
  output logic seq_pos_o
);

  if (GEAR_BITS < 1 || GEAR_BITS > GEAR_W) begin : g_bad_gear
    $error("GEAR_BITS out of range");
  end

  typedef enum logic [1:0] {st_load, st_check, st_run} phase_t;

  phase_t phase_reg;
  logic [IDX_W-1:0] load_idx_reg;
  op_entry_t ram_reg [ENTRY_COUNT];
  param_t ram_param_reg;
  param_t act_reg;
  op_entry_t app_reg;
  logic signed [POS_W-1:0] pos_reg;
  logic signed [MROT_W-1:0] mrot_reg;
  logic origin_reg;
  logic warn_reg;
  logic wrap_alarm_reg;
  logic rth_alarm_reg;
  logic wr_err_reg;
  logic entry_ok;
  logic param_ok;
  logic wrap_on;
  logic gear_ok;
  logic signed [POS_W:0] range_s;

  function automatic update_class_t field_class(input int unsigned f);
    // 0 wrap, 1 gears, 2 immediate bits, 3 rate settings
    unique case (f)
      0: field_class = upd_after_config;
      1: field_class = upd_after_power;
      2: field_class = upd_immediate;
      default: field_class = upd_after_stop;
    endcase
  endfunction

  // Range checks on host writes
  always_comb begin
    entry_ok = (entry_data_i.speed <= SPEED_MAX) &&
      (entry_data_i.accel >= RATE_MIN) && (entry_data_i.accel <= RATE_MAX) &&
      (entry_data_i.decel >= RATE_MIN) && (entry_data_i.decel <= RATE_MAX) &&
      (entry_data_i.push_current <= PUSH_MAX) &&
      (entry_data_i.dwell <= DWELL_MAX);
    param_ok = (param_data_i.wrap_range >= WRAP_RANGE_MIN) &&
      (param_data_i.gear_a != '0) && (param_data_i.gear_b != '0) &&
      (param_data_i.common_accel >= RATE_MIN) &&
      (param_data_i.common_decel >= RATE_MIN);
  end

  // Power-up copy from storage, one entry per cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_reg <= st_load;
      load_idx_reg <= '0;
    end else begin
      unique case (phase_reg)
        st_load: begin
          load_idx_reg <= load_idx_reg + 6'h01;
          if (load_idx_reg == LAST_IDX) begin
            phase_reg <= st_check;
          end
        end
        st_check: phase_reg <= st_run;
        st_run: phase_reg <= st_run;
      endcase
    end
  end

  // Working copy: storage at power-up, host writes afterwards only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < ENTRY_COUNT; i++) begin
        ram_reg[i] <= ENTRY_RST;
      end
    end else if (phase_reg == st_load) begin
      ram_reg[load_idx_reg] <= nvm_entry_i;
    end else if (phase_reg == st_run && entry_wr_i && entry_ok) begin
      ram_reg[entry_idx_i] <= entry_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ram_param_reg <= PARAM_RST;
    end else if (phase_reg == st_load && load_idx_reg == '0) begin
      ram_param_reg <= nvm_param_i;
    end else if (phase_reg == st_run && param_wr_i && param_ok) begin
      ram_param_reg <= param_data_i;
    end
  end

  // Write errors are refused silently except for this pulse
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_err_reg <= 1'b0;
    end else begin
      wr_err_reg <= phase_reg == st_run &&
        ((entry_wr_i && !entry_ok) || (param_wr_i && !param_ok));
    end
  end

  // Active settings follow the working copy by update class
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      act_reg <= PARAM_RST;
    end else if (phase_reg == st_check) begin
      act_reg <= ram_param_reg;
    end else if (phase_reg == st_run) begin
      if (field_class(2) == upd_immediate) begin
        act_reg.rth_alarm_enable <= ram_param_reg.rth_alarm_enable;
        act_reg.soft_ot_enable <= ram_param_reg.soft_ot_enable;
      end
      if (field_class(3) == upd_after_stop && !motion_i) begin
        act_reg.rate_separate <= ram_param_reg.rate_separate;
        act_reg.common_accel <= ram_param_reg.common_accel;
        act_reg.common_decel <= ram_param_reg.common_decel;
      end
      if (field_class(0) == upd_after_config && config_i) begin
        act_reg.wrap_enable <= ram_param_reg.wrap_enable;
        act_reg.wrap_range <= ram_param_reg.wrap_range;
      end
      // Gears change only through the power-up copy
    end
  end

  assign wrap_on = act_reg.wrap_enable;
  assign range_s = $signed({2'b00, act_reg.wrap_range});

  // Gear divisibility; wide divide kept combinational for simplicity
  function automatic logic gear_ok_load(input param_t p);
    logic [25:0] n1;
    logic [21:0] d1;
    logic [44:0] n2;
    n1 = 26'(p.gear_b[GEAR_BITS-1:0] * GEAR_B_FACTOR);
    d1 = 22'(p.gear_a[GEAR_BITS-1:0] * GEAR_A_FACTOR);
    n2 = 45'(p.wrap_range * d1);
    gear_ok_load = (d1 != '0) && (n1 != '0) &&
      (n1 % 26'(d1) == '0) && (n2 % 45'(n1) == '0);
  endfunction

  assign gear_ok = gear_ok_load(act_reg);

  // Command position counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pos_reg <= '0;
      mrot_reg <= '0;
    end else if (preset_i || home_done_i) begin
      pos_reg <= '0;
      mrot_reg <= '0;
    end else if (wrap_on && (pos_reg < 0 || $signed({pos_reg[POS_W-1],
                 pos_reg}) >= range_s)) begin
      pos_reg <= '0;
      mrot_reg <= '0;
    end else if (step_i && wrap_on) begin
      if (step_up_i && $signed({pos_reg[POS_W-1], pos_reg})
          >= range_s - 25'sh1) begin
        pos_reg <= '0;
        mrot_reg <= '0;
      end else if (!step_up_i && pos_reg == '0) begin
        pos_reg <= POS_W'(act_reg.wrap_range - 23'h1);
      end else begin
        pos_reg <= step_up_i ? pos_reg + 24'sh1 : pos_reg - 24'sh1;
      end
    end else if (step_i) begin
      pos_reg <= step_up_i ? pos_reg + 24'sh1 : pos_reg - 24'sh1;
      if (step_up_i && pos_reg == {1'b0, {(POS_W-1){1'b1}}}) begin
        mrot_reg <= mrot_reg + 16'sh1;
      end else if (!step_up_i && pos_reg == {1'b1, {(POS_W-1){1'b0}}}) begin
        mrot_reg <= mrot_reg - 16'sh1;
      end
    end
  end

  // Origin and alarms; a set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      origin_reg <= 1'b0;
    end else if (preset_i || home_done_i) begin
      origin_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      warn_reg <= 1'b0;
    end else begin
      warn_reg <= wrap_on && !gear_ok;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wrap_alarm_reg <= 1'b0;
    end else if ((phase_reg == st_run && config_i && warn_reg) ||
                 (phase_reg == st_check && ram_param_reg.wrap_enable &&
                  !gear_ok_load(ram_param_reg))) begin
      wrap_alarm_reg <= 1'b1;
    end else if (alarm_clr_i) begin
      wrap_alarm_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rth_alarm_reg <= 1'b0;
    end else if (start_pos_i && !origin_reg && act_reg.rth_alarm_enable) begin
      rth_alarm_reg <= 1'b1;
    end else if (alarm_clr_i) begin
      rth_alarm_reg <= 1'b0;
    end
  end

  // Selected entry is latched only while stopped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      app_reg <= ENTRY_RST;
    end else if (!motion_i) begin
      app_reg <= ram_reg[sel_idx_i];
    end
  end

  // Setup outputs derived from the applied entry
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      target_o <= '0;
      eff_accel_o <= RATE_RST;
      eff_decel_o <= RATE_RST;
      push_current_o <= '0;
      dwell_o <= '0;
      linked_o <= 1'b0;
      push_mode_o <= 1'b0;
      seq_pos_o <= 1'b0;
      entry_o <= ENTRY_RST;
    end else begin
      entry_o <= app_reg;
      target_o <= (app_reg.mode == absolute_target_mode) ? app_reg.position
        : pos_reg + app_reg.position;
      eff_accel_o <= act_reg.rate_separate ? app_reg.accel
        : act_reg.common_accel;
      eff_decel_o <= act_reg.rate_separate ? app_reg.decel
        : act_reg.common_decel;
      push_current_o <= (app_reg.chain == chain_push) ?
        app_reg.push_current : '0;
      dwell_o <= (app_reg.chain == chain_linked_dwell) ?
        app_reg.dwell : '0;
      linked_o <= app_reg.chain == chain_linked ||
        app_reg.chain == chain_linked_dwell;
      push_mode_o <= app_reg.chain == chain_push;
      seq_pos_o <= app_reg.seq_enable;
    end
  end

  // Plain status outputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      nvm_addr_o <= '0;
      ready_o <= 1'b0;
      wr_err_o <= 1'b0;
      cmd_pos_o <= '0;
      multi_rot_o <= '0;
      soft_ot_en_o <= 1'b0;
      wrap_warn_o <= 1'b0;
      wrap_alarm_o <= 1'b0;
      rth_alarm_o <= 1'b0;
      origin_set_o <= 1'b0;
    end else begin
      nvm_addr_o <= (phase_reg == st_load) ? load_idx_reg + 6'h01 : '0;
      ready_o <= phase_reg == st_run;
      wr_err_o <= wr_err_reg;
      cmd_pos_o <= pos_reg;
      multi_rot_o <= mrot_reg;
      soft_ot_en_o <= act_reg.soft_ot_enable && !wrap_on;
      wrap_warn_o <= warn_reg;
      wrap_alarm_o <= wrap_alarm_reg;
      rth_alarm_o <= rth_alarm_reg;
      origin_set_o <= origin_reg;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_up_at_top;
    wrap_on && step_i && step_up_i && !preset_i && !home_done_i &&
      pos_reg >= 0 && $signed({pos_reg[POS_W-1], pos_reg}) == range_s - 25'sh1;
  endsequence

  sequence s_load_done;
    phase_reg == st_load && load_idx_reg == LAST_IDX;
  endsequence

  a_wrap_top_clear: assert property (
    s_up_at_top |=> pos_reg == '0 && mrot_reg == '0)
    else $error("wrap did not clear position");
  a_wrap_in_range: assert property (
    wrap_on ##1 $stable(act_reg.wrap_range) |-> pos_reg >= 0 &&
      $signed({pos_reg[POS_W-1], pos_reg}) < range_s)
    else $error("position out of wrap range");
  a_wrap_under: assert property (
    wrap_on && step_i && !step_up_i && pos_reg == '0 && !preset_i &&
      !home_done_i |=> pos_reg == POS_W'($past(act_reg.wrap_range) - 23'h1))
    else $error("wrap below zero wrong");
  a_soft_ot_off: assert property (
    wrap_on |=> !soft_ot_en_o)
    else $error("soft overtravel active while wrapping");
  a_gear_warn: assert property (
    wrap_on && !gear_ok |=> ##1 wrap_warn_o)
    else $error("gear warning missing");
  a_warn_escalate: assert property (
    phase_reg == st_run && config_i && warn_reg |=> ##1 wrap_alarm_o)
    else $error("wrap alarm not raised");
  a_rth_alarm: assert property (
    start_pos_i && !origin_reg && act_reg.rth_alarm_enable |=> ##1 rth_alarm_o)
    else $error("homing alarm missing");
  a_defer_apply: assert property (
    motion_i |=> $stable(app_reg))
    else $error("entry changed during motion");
  a_load_then_run: assert property (
    s_load_done |=> phase_reg == st_check ##1 phase_reg == st_run ##1 ready_o)
    else $error("load sequence broken");
  a_common_rate: assert property (
    !act_reg.rate_separate |=> eff_accel_o == $past(act_reg.common_accel))
    else $error("common rate not used");

endmodule // wrap_position_ctrl

`default_nettype wire

// ---- verif/nvm_store_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module nvm_store_model
  import wrap_pos_pkg::*;
(
  input wire logic [IDX_W-1:0] addr_i,
  input wire logic bad_gear_i,
  output op_entry_t entry_o,
  output param_t param_o
);
  // Read-only image: no write port, so host writes can never land here
  always_comb begin
    entry_o = ENTRY_RST;
    entry_o.position = {{(POS_W-IDX_W){1'b1}}, addr_i};
    entry_o.speed = 20'h00064 + RATE_W'(addr_i);
    entry_o.chain = chain_t'(addr_i[1:0]);
    entry_o.dwell = DWELL_W'(addr_i);
    param_o = PARAM_RST;
    // Gear A of 3 breaks the integer check on purpose
    param_o.wrap_enable = bad_gear_i;
    param_o.gear_a = bad_gear_i ? 16'h0003 : GEAR_RST;
  end
endmodule // nvm_store_model
`default_nettype wire

// ---- verif/wrap_position_and_operation_table_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module wrap_position_and_operation_table_tb_top
  import wrap_pos_pkg::*;
;
  logic clk_i, rst_n_i, step_up, motion, entry_wr, param_wr, bad_gear;
  logic [5:0] pls;
  logic [IDX_W-1:0] sel_idx, entry_idx, nvm_addr;
  op_entry_t entry_data, nvm_entry, entry, e;
  param_t param_data, nvm_param, p;
  logic ready, wr_err, soft_ot, warn, alarm, rth, origin;
  logic linked, push_mode, seq_pos;
  logic signed [POS_W-1:0] cmd_pos, target;
  logic signed [MROT_W-1:0] multi_rot;
  logic [RATE_W-1:0] eff_accel, eff_decel;
  logic [PUSH_W-1:0] push_cur;
  logic [DWELL_W-1:0] dwell;
  int n_errors = 0;
  int n_tests = 0;
  int i;

  wrap_position_ctrl wrap_position_ctrl_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .step_i(pls[0]),
    .step_up_i(step_up), .preset_i(pls[1]), .home_done_i(pls[2]),
    .motion_i(motion), .start_pos_i(pls[3]), .config_i(pls[4]),
    .alarm_clr_i(pls[5]), .sel_idx_i(sel_idx), .entry_wr_i(entry_wr),
    .entry_idx_i(entry_idx), .entry_data_i(entry_data),
    .param_wr_i(param_wr), .param_data_i(param_data),
    .nvm_entry_i(nvm_entry), .nvm_param_i(nvm_param),
    .nvm_addr_o(nvm_addr), .ready_o(ready), .wr_err_o(wr_err),
    .cmd_pos_o(cmd_pos), .multi_rot_o(multi_rot), .soft_ot_en_o(soft_ot),
    .wrap_warn_o(warn), .wrap_alarm_o(alarm), .rth_alarm_o(rth),
    .origin_set_o(origin), .entry_o(entry), .target_o(target),
    .eff_accel_o(eff_accel), .eff_decel_o(eff_decel),
    .push_current_o(push_cur), .dwell_o(dwell), .linked_o(linked),
    .push_mode_o(push_mode), .seq_pos_o(seq_pos)
  );

  nvm_store_model nvm_store_model_inst (
    .addr_i(nvm_addr), .bad_gear_i(bad_gear),
    .entry_o(nvm_entry), .param_o(nvm_param)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic pulse(input int b);
    pls[b] = 1'b1;
    tick(1);
    pls[b] = 1'b0;
    tick(3);
  endtask

  task automatic wr_entry(input op_entry_t d);
    entry_idx = LAST_IDX;
    entry_data = d;
    entry_wr = 1'b1;
    tick(1);
    entry_wr = 1'b0;
  endtask

  task automatic wr_param(input param_t d);
    param_data = d;
    param_wr = 1'b1;
    tick(1);
    param_wr = 1'b0;
    tick(3);
  endtask

  // Storage is read only after reset release, so a power cycle is a reset
  task automatic power_up();
    int k;
    rst_n_i = 1'b0;
    tick(6);
    chk(entry, ENTRY_RST);
    chk(eff_accel, RATE_RST);
    chk(cmd_pos, 24'h000000);
    rst_n_i = 1'b1;
    for (k = 0; k < 100 && ready !== 1'b1; k++) tick(1);
    chk(ready, 1'b1);
    tick(3);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // About 270 cycles expected; far beyond that means a hang
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end

  initial begin
    rst_n_i = 1'b0;
    pls = '0;
    step_up = 1'b0;
    motion = 1'b0;
    entry_wr = 1'b0;
    param_wr = 1'b0;
    bad_gear = 1'b0;
    sel_idx = 6'h05;
    entry_idx = '0;
    entry_data = ENTRY_RST;
    param_data = PARAM_RST;
    power_up();
    chk(entry.speed, 20'h00069);
    chk(entry.position, 24'shffffc5);
    chk(linked, 1'b1);
    sel_idx = LAST_IDX;
    tick(3);
    chk(entry.dwell, 16'h003f);
    chk(push_mode, 1'b1);
    chk(push_cur, PUSH_RST);
    $display("test table load done");
    for (i = 0; i < 5; i++) begin
      e = ENTRY_RST;
      case (i)
        0: e.speed = SPEED_MAX + 20'h00001;
        1: e.accel = 20'h00000;
        2: e.decel = RATE_MAX + 20'h00001;
        3: e.push_current = PUSH_MAX + 9'h001;
        default: e.dwell = DWELL_MAX + 16'h0001;
      endcase
      wr_entry(e);
      tick(1);
      chk(wr_err, 1'b1);
      tick(1);
      chk(wr_err, 1'b0);
    end
    chk(entry.dwell, 16'h003f);
    $display("test range refusal done");
    e = '{position: 24'h800000, speed: SPEED_MAX,
      mode: absolute_target_mode, chain: chain_linked_dwell,
      accel: RATE_MIN, decel: RATE_MAX, push_current: PUSH_MAX,
      seq_enable: 1'b1, dwell: DWELL_MAX};
    motion = 1'b1;
    wr_entry(e);
    tick(3);
    chk(wr_err, 1'b0);
    chk(entry.dwell, 16'h003f);
    motion = 1'b0;
    tick(3);
    chk(entry, e);
    chk(target, 24'sh800000);
    chk(seq_pos, 1'b1);
    chk(eff_accel, RATE_MIN);
    chk(eff_decel, RATE_MAX);
    e.mode = target_incremental;
    for (i = 0; i < 4; i++) begin
      e.chain = chain_t'(i);
      wr_entry(e);
      tick(3);
      chk(linked, i == 1 || i == 2);
      chk(push_mode, i == 3);
      chk(dwell, (i == 2) ? DWELL_MAX : 16'h0000);
      chk(push_cur, (i == 3) ? PUSH_MAX : 9'h000);
    end
    $display("test entry fields done");
    p = PARAM_RST;
    p.rate_separate = 1'b0;
    p.common_accel = 20'h00077;
    p.common_decel = 20'h00088;
    motion = 1'b1;
    wr_param(p);
    chk(eff_accel, RATE_MIN);
    motion = 1'b0;
    tick(3);
    chk(eff_accel, 20'h00077);
    chk(eff_decel, 20'h00088);
    $display("test common rates done");
    chk(origin, 1'b0);
    pulse(3);
    chk(rth, 1'b0);
    p.rth_alarm_enable = 1'b1;
    wr_param(p);
    pulse(3);
    chk(rth, 1'b1);
    pulse(5);
    chk(rth, 1'b0);
    pulse(2);
    chk(origin, 1'b1);
    pulse(3);
    chk(rth, 1'b0);
    $display("test homing alarm done");
    p.wrap_enable = 1'b1;
    p.wrap_range = 23'h000014;
    p.soft_ot_enable = 1'b1;
    wr_param(p);
    chk(soft_ot, 1'b1);
    pulse(4);
    chk(soft_ot, 1'b0);
    chk(warn, 1'b0);
    pulse(1);
    pulse(0);
    chk(cmd_pos, 24'h000013);
    step_up = 1'b1;
    pulse(0);
    chk(cmd_pos, 24'h000000);
    chk(multi_rot, 16'h0000);
    pulse(0);
    chk(cmd_pos, 24'h000001);
    chk(target, 24'sh800001);
    $display("test wrap stepping done");
    p.wrap_range = 23'h000015;
    wr_param(p);
    pulse(4);
    chk(warn, 1'b1);
    chk(alarm, 1'b0);
    pulse(4);
    chk(alarm, 1'b1);
    pulse(5);
    chk(alarm, 1'b0);
    p.wrap_enable = 1'b0;
    wr_param(p);
    pulse(4);
    chk(warn, 1'b0);
    chk(soft_ot, 1'b1);
    $display("test wrap warning done");
    bad_gear = 1'b1;
    power_up();
    chk(entry.dwell, 16'h003f);
    chk(warn, 1'b1);
    chk(alarm, 1'b1);
    $display("test power cycle done");
    end_of_test();
  end
endmodule // wrap_position_and_operation_table_tb_top
`default_nettype wire
